// ==== hdl/dars_pkg.sv ====
// constants and types shared by the dram access/refresh sequencer
// assumes one 125 MHz system clock; all pins are synchronous to it
package dars_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int          ADDR_W    = 10;      // row, column and q width
  localparam int          BANKS     = 4;       // one row strobe per bank
  localparam int          BANK_W    = 2;       // bank select width
  localparam int          REF_W     = 9;       // refresh counter width
  localparam logic [8:0]  REF_MAX   = 9'h1ff;  // last count before wrap
  localparam logic [2:0]  FR_ON     = 3'h2;    // gen clock fall: strobes low
  localparam logic [2:0]  FR_OFF    = 3'h4;    // gen clock fall: strobes high

  // ****************************************************************
  // timing, in ns and derived cycles (least times round up)
  // ****************************************************************
  localparam int CLK_NS      = 8;   // 125 MHz
  localparam int HOLD_HI_NS  = 15;  // row hold with hold select high
  localparam int HOLD_LO_NS  = 8;   // row hold with hold select low
  localparam int COL_DLY_NS  = 8;   // column address to column strobe
  localparam int HOLD_HI_CYC = (HOLD_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_LO_CYC = (HOLD_LO_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_DLY_CYC = (COL_DLY_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  // order follows the two mode pins {hi, lo}
  typedef enum logic [1:0] {
    MD_EXT_REF, MD_FORCED, MD_EXT_ACC, MD_AUTO_ACC
  } dars_mode_t;

  // automatic access sequencer
  typedef enum logic [2:0] {
    AA_IDLE, AA_HOLD, AA_COL, AA_CAS, AA_HREF
  } dars_aa_t;

  // everything that goes to the dram array
  typedef struct packed {
    logic [BANKS-1:0]  ras_n;  // per-bank row strobes
    logic              cas_n;  // column strobe
    logic              we_n;   // write enable
    logic [ADDR_W-1:0] addr;   // multiplexed address
  } dars_dram_t;

endpackage : dars_pkg

// ==== hdl/dars_sequencer.sv ====
// dram access and refresh sequencer: four modes, hidden/forced refresh
// assumes all inputs synchronous to mclk_in; the request pin is
// open-drain, its wire level returned on refresh_request_io_in
`timescale 1ns/1ns
`default_nettype none

module dars_sequencer #(
  parameter int unsigned HOLD_HI_CYC = dars_pkg::HOLD_HI_CYC,  // row hold, select high
  parameter int unsigned HOLD_LO_CYC = dars_pkg::HOLD_LO_CYC,  // row hold, select low
  parameter int unsigned COL_DLY_CYC = dars_pkg::COL_DLY_CYC   // column to strobe
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_in,
  input  wire logic                          mode_sel_hi_in,
  input  wire logic                          mode_sel_lo_in,
  input  wire logic                          row_strobe_n_in,
  input  wire logic                          col_strobe_n_in,
  input  wire logic                          write_enable_n_in,
  input  wire logic                          row_col_sel_in,
  input  wire logic                          refresh_period_clock_in,
  input  wire logic                          refresh_strobe_gen_clock_in,
  input  wire logic                          chip_sel_n_in,
  input  wire logic                          row_hold_select_in,
  input  wire logic                          address_latch_strobe_in,
  input  wire logic [dars_pkg::ADDR_W-1:0]   row_addr_in,
  input  wire logic [dars_pkg::ADDR_W-1:0]   col_addr_in,
  input  wire logic                          bank_sel_lo_in,
  input  wire logic                          bank_sel_hi_in,
  input  wire logic                          refresh_request_io_in,
  output logic                               refresh_request_io_out,
  output logic                               refresh_request_io_oe_n_out,
  output var dars_pkg::dars_dram_t           dram_out
);
  import dars_pkg::*;

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  // the delay counter is four bits and a zero count would wrap to 15
  if (HOLD_HI_CYC < 1 || HOLD_HI_CYC > 15 || HOLD_LO_CYC < 1 ||
      HOLD_LO_CYC > 15 || COL_DLY_CYC < 1 || COL_DLY_CYC > 15) begin : g_bad
    $error("dars_sequencer: delay counts must be 1..15");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  dars_mode_t          mode;          // decoded mode pins
  dars_mode_t          mode_r;        // mode one cycle ago
  logic                row_strobe_in_r;       // previous row strobe input
  logic                refresh_period_clock_r;        // previous period clock
  logic                refresh_strobe_gen_clock_r;        // previous generator clock
  logic                rcsel_d_r;     // previous row/column select
  logic [ADDR_W-1:0]   row_lat_r;     // row address latch
  logic [ADDR_W-1:0]   col_lat_r;     // column address latch
  logic [BANK_W-1:0]   bank_lat_r;    // bank latch
  logic [REF_W-1:0]    refr_cnt_r;    // refresh row counter
  logic                refreshed_r;   // refresh seen this period
  logic                refresh_request_r; // request pending
  logic                f1_ext_r;      // forced mode acts as external
  logic [2:0]          fr_cnt_r;      // generator falls since entry
  dars_aa_t            aa_r;          // auto access state
  dars_aa_t            aa_nxt;
  logic [3:0]          cnt_r;         // auto access delay count
  logic [3:0]          cnt_nxt;
  dars_dram_t          dram_r;        // registered dram outputs
  dars_dram_t          dram_nxt;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign mode = dars_mode_t'({mode_sel_hi_in, mode_sel_lo_in});

  wire m_ext_ref = (mode == MD_EXT_REF);
  wire m_forced  = (mode == MD_FORCED);
  wire m_ext_acc = (mode == MD_EXT_ACC);
  wire m_auto    = (mode == MD_AUTO_ACC);

  // edges of the sampled strobes and clocks
  wire row_strobe_in_fall = row_strobe_in_r & ~row_strobe_n_in;
  wire row_strobe_in_rise = ~row_strobe_in_r & row_strobe_n_in;
  wire refresh_period_clock_fall  = refresh_period_clock_r & ~refresh_period_clock_in;
  wire refresh_strobe_gen_clock_fall  = refresh_strobe_gen_clock_r & ~refresh_strobe_gen_clock_in;

  // fall-through latches: transparent while the strobe is high
  wire [ADDR_W-1:0] row_eff  = address_latch_strobe_in ? row_addr_in : row_lat_r;
  wire [ADDR_W-1:0] col_eff  = address_latch_strobe_in ? col_addr_in : col_lat_r;
  wire [BANK_W-1:0] bank_eff = address_latch_strobe_in ?
                               {bank_sel_hi_in, bank_sel_lo_in} : bank_lat_r;

  // forced mode entered with period clock high behaves as external refresh
  wire f1_entry = m_forced & (mode_r != MD_FORCED);
  wire f1_ext   = m_forced & (f1_entry ? refresh_period_clock_in : f1_ext_r);
  wire ext_ref  = m_ext_ref | f1_ext;
  wire forced   = m_forced & ~f1_ext;
  wire fr_low   = forced & (fr_cnt_r >= FR_ON) & (fr_cnt_r < FR_OFF);

  // hidden refresh window: deselected, period clock high, none yet
  wire hid_win = m_auto & chip_sel_n_in & refresh_period_clock_in &
                 ~refreshed_r;
  wire in_href = (aa_r == AA_HREF);
  wire href_on = in_href | (hid_win & (aa_r == AA_IDLE));
  wire ref_on  = ext_ref | forced | href_on;
  wire aa_col  = (aa_r == AA_COL) | (aa_r == AA_CAS);
  wire aa_busy = (aa_r == AA_HOLD) | aa_col;

  // refresh completions, each advancing the counter once
  wire ext_done  = ext_ref & row_strobe_in_rise;
  wire href_done = in_href & row_strobe_n_in;
  wire fr_done   = forced & refresh_strobe_gen_clock_fall & (fr_cnt_r == FR_OFF - 3'h1);
  wire fr_abort  = ~forced & (fr_cnt_r >= FR_ON) & (fr_cnt_r < FR_OFF);
  wire inc       = ext_done | href_done | fr_done | fr_abort;
  // our own drive hides an external pull, so only sample when idle
  wire ext_clr   = ~refresh_request_io_in & ~refresh_request_r;

  // request set on the falling period clock unless refreshed
  wire req_set = refresh_period_clock_fall & ~refreshed_r & ~in_href & ~inc;
  wire fr_on_evt = forced & refresh_strobe_gen_clock_fall & (fr_cnt_r == FR_ON - 3'h1);
  wire req_clr = m_ext_ref | fr_on_evt;

  // one row strobe per bank, gated by the selected bank
  logic [BANKS-1:0] bank_ras_n;
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign bank_ras_n[b] = ~((bank_eff == BANK_W'(b)) & ~row_strobe_n_in);
  end

  // ****************************************************************
  // automatic access sequencer
  // ****************************************************************
  // row strobe fall starts an access or, in the window, a refresh
  always_comb begin
    aa_nxt  = aa_r;
    cnt_nxt = cnt_r;
    unique case (aa_r)
      AA_IDLE: begin
        if (m_auto & row_strobe_in_fall & hid_win) begin
          aa_nxt = AA_HREF;
        end else if (m_auto & row_strobe_in_fall & ~chip_sel_n_in) begin
          aa_nxt  = AA_HOLD;
          cnt_nxt = row_hold_select_in ? 4'(HOLD_HI_CYC) : 4'(HOLD_LO_CYC);
        end
      end
      AA_HOLD: begin
        if (row_strobe_n_in | ~m_auto) begin
          aa_nxt = AA_IDLE;
        end else if (cnt_r == 4'h1) begin
          aa_nxt  = AA_COL;
          cnt_nxt = 4'(COL_DLY_CYC);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      AA_COL: begin
        if (row_strobe_n_in | ~m_auto) begin
          aa_nxt = AA_IDLE;
        end else if (cnt_r == 4'h1) begin
          aa_nxt = AA_CAS;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      AA_CAS: begin
        if (row_strobe_n_in | ~m_auto) begin
          aa_nxt = AA_IDLE;
        end
      end
      // runs to the strobe rise whatever the period clock does
      AA_HREF: begin
        if (row_strobe_n_in) begin
          aa_nxt = AA_IDLE;
        end
      end
      default: aa_nxt = AA_IDLE; // three-bit code has spare values
    endcase
  end

  // ****************************************************************
  // dram output selection
  // ****************************************************************
  always_comb begin
    dram_nxt.we_n = write_enable_n_in;
    // address: counter, select pin, or sequencer phase
    if (ref_on) begin
      dram_nxt.addr = {1'b0, refr_cnt_r};
    end else if (m_ext_acc) begin
      dram_nxt.addr = row_col_sel_in ? row_eff : col_eff;
    end else begin
      dram_nxt.addr = aa_col ? col_eff : row_eff;
    end
    // row strobes: all follow the input in external or hidden refresh, all from the generator count in forced, one bank in access
    if (ext_ref | href_on) begin
      dram_nxt.ras_n = {BANKS{row_strobe_n_in}};
    end else if (forced) begin
      dram_nxt.ras_n = {BANKS{~fr_low}};
    end else if (m_ext_acc | (m_auto & (~chip_sel_n_in | aa_busy))) begin
      dram_nxt.ras_n = bank_ras_n;
    end else begin
      dram_nxt.ras_n = {BANKS{1'b1}};
    end
    // column strobe: held off while the row address is out
    if (m_ext_acc) begin
      // one cycle after the switch gives column address setup
      dram_nxt.cas_n = row_col_sel_in | rcsel_d_r | col_strobe_n_in;
    end else begin
      dram_nxt.cas_n = ~(m_auto & (aa_r == AA_CAS) & ~row_strobe_n_in);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // sampled inputs and edge history
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_r    <= MD_EXT_REF;
      row_strobe_in_r   <= 1'b1;
      refresh_period_clock_r    <= 1'b0;
      refresh_strobe_gen_clock_r    <= 1'b0;
      rcsel_d_r <= 1'b1;
    end else begin
      mode_r    <= mode;
      row_strobe_in_r   <= row_strobe_n_in;
      refresh_period_clock_r    <= refresh_period_clock_in;
      refresh_strobe_gen_clock_r    <= refresh_strobe_gen_clock_in;
      rcsel_d_r <= row_col_sel_in;
    end
  end

  // address latches close when the latch strobe is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      row_lat_r  <= '0;
      col_lat_r  <= '0;
      bank_lat_r <= '0;
    end else if (address_latch_strobe_in) begin
      row_lat_r  <= row_addr_in;
      col_lat_r  <= col_addr_in;
      bank_lat_r <= {bank_sel_hi_in, bank_sel_lo_in};
    end
  end

  // refresh counter: external clear beats an increment
  always_ff @(posedge mclk_in) begin
    if (rst_in | ext_clr) begin
      refr_cnt_r <= '0;
    end else if (inc) begin
      refr_cnt_r <= (refr_cnt_r == REF_MAX) ? '0 : refr_cnt_r + 9'h001;
    end
  end

  // period bookkeeping and the request flag; set wins over clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      refreshed_r       <= 1'b0;
      refresh_request_r <= 1'b0;
    end else begin
      // a hidden refresh that spans the fall belongs to the period it started in,
      // so finishing it with the period clock low must not hide the next request
      refreshed_r       <= refresh_period_clock_fall ? 1'b0 :
                           (refreshed_r | (inc & refresh_period_clock_in));
      refresh_request_r <= req_set | (refresh_request_r & ~req_clr);
    end
  end

  // forced refresh: count generator falls while forced
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      f1_ext_r <= 1'b0;
      fr_cnt_r <= 3'h0;
    end else begin
      f1_ext_r <= f1_ext;
      if (~forced) begin
        fr_cnt_r <= 3'h0;
      end else if (refresh_strobe_gen_clock_fall & (fr_cnt_r < FR_OFF)) begin
        fr_cnt_r <= fr_cnt_r + 3'h1;
      end
    end
  end

  // sequencer and outputs
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aa_r   <= AA_IDLE;
      cnt_r  <= 4'h0;
      dram_r <= '{ras_n: '1, cas_n: 1'b1, we_n: 1'b1, addr: '0};
    end else begin
      aa_r   <= aa_nxt;
      cnt_r  <= cnt_nxt;
      dram_r <= dram_nxt;
    end
  end

  // open-drain request: drive low only while pending
  assign refresh_request_io_out      = 1'b0;
  assign refresh_request_io_oe_n_out = ~refresh_request_r;
  assign dram_out                    = dram_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_EXT_ONE_BANK: assert property (
    (m_ext_acc && !row_strobe_n_in) |=> ($countones(~dram_r.ras_n) == 1))
    else $error("external access did not strobe exactly one bank");
  AST_WE_TRACK: assert property (
    (mode == $past(mode)) |=> (dram_r.we_n == $past(write_enable_n_in)))
    else $error("write enable output does not track its input");
  AST_CAS_ROW_OFF: assert property (
    (m_ext_acc && row_col_sel_in) |=> dram_r.cas_n)
    else $error("column strobe asserted while row address selected");
  AST_CAS_COPY: assert property (
    (m_ext_acc && !row_col_sel_in && !rcsel_d_r)
      |=> (dram_r.cas_n == $past(col_strobe_n_in)))
    else $error("column strobe does not copy its input");
  AST_ADDR_ROW: assert property (
    (m_ext_acc && row_col_sel_in) |=> (dram_r.addr == $past(row_eff)))
    else $error("row address not driven while select high");
  AST_ADDR_COL: assert property (
    (m_ext_acc && !row_col_sel_in) |=> (dram_r.addr == $past(col_eff)))
    else $error("column address not driven while select low");
  AST_AUTO_HOLD: assert property (
    (aa_r == AA_IDLE && aa_nxt == AA_HOLD && row_hold_select_in)
      |=> (dram_r.cas_n && !dram_r.ras_n[$past(bank_eff)]) [*3])
    else $error("auto access column strobe too early");
  AST_REQ_SET: assert property (
    req_set |=> (refresh_request_r && !refresh_request_io_oe_n_out))
    else $error("refresh request not raised on period clock fall");
  AST_REQ_M0: assert property (
    (m_ext_ref && !req_set) |=> !refresh_request_r)
    else $error("external refresh mode left request pending");
  AST_CNT_WRAP: assert property (
    (refr_cnt_r == REF_MAX && inc && !ext_clr) |=> (refr_cnt_r == '0))
    else $error("refresh counter did not wrap after 511");
  AST_ONE_HIDDEN: assert property (
    (href_done && refresh_period_clock_in) |=> !hid_win)
    else $error("second hidden refresh window in one period");

endmodule : dars_sequencer

`default_nettype wire

// ==== tb/dars_partner_model.sv ====
// far side model: open-drain request wire and a dram bank that latches addresses
// assumes the registered dram bus is sampled on the sequencer clock
`timescale 1ns/1ns
`default_nettype none
module dars_partner_model (
  input  wire logic                   mclk_in,
  input  var  dars_pkg::dars_dram_t   dram_in,
  input  wire logic                   req_data_in,
  input  wire logic                   req_oe_n_in,
  input  wire logic                   ext_pull_n_in,
  output logic                        req_wire_out,
  output logic [dars_pkg::ADDR_W-1:0] row_seen_out,
  output logic [dars_pkg::ADDR_W-1:0] col_seen_out
);
  import dars_pkg::*;
  dars_dram_t prev_r;  // bus one cycle back, for strobe falls
  // ****************************************************************
  // wire and array behaviour
  // ****************************************************************
  // pull-up unless the sequencer or our external gate pulls low
  assign req_wire_out = (req_oe_n_in | req_data_in) & ext_pull_n_in;
  // dram latches row on any row strobe fall, column on column fall
  always_ff @(posedge mclk_in) begin
    prev_r <= dram_in;
    if ((prev_r.ras_n & ~dram_in.ras_n) != 4'h0) begin
      row_seen_out <= dram_in.addr;
    end
    if (prev_r.cas_n && !dram_in.cas_n) begin
      col_seen_out <= dram_in.addr;
    end
  end
endmodule : dars_partner_model
`default_nettype wire

// ==== tb/dars_sequencer_tb.sv ====
// self-checking bench for the dram access and refresh sequencer
// assumes default hold and column delay counts; inputs change at falling edge
`timescale 1ns/1ns
`default_nettype none
module dars_sequencer_tb;
  import dars_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic             clk = 1'b0, rst = 1'b1, md_hi = 1'b0, md_lo = 1'b0;
  logic             ras_i = 1'b1, cas_i = 1'b1, we_i = 1'b1, rcs = 1'b1;
  logic             refresh_period_clock = 1'b0, gck = 1'b1, cs_n = 1'b1, row_hold_select = 1'b1;
  logic             address_latch_strobe = 1'b1, b_lo = 1'b0, b_hi = 1'b0, pull_n = 1'b1;
  logic [9:0]       row_a = 10'h000, col_a = 10'h000, row_seen, col_seen;
  logic             req_o, req_oe_n, req_wire;
  dars_dram_t       dram;
  logic [8:0]       exp_cnt = 9'h000;  // refresh counter as we expect it
  int               n_errors = 0, check_count = 0;
  always #4 clk = ~clk;  // 125 MHz
  dars_sequencer #(.HOLD_HI_CYC(2), .HOLD_LO_CYC(1), .COL_DLY_CYC(1)) dars_sequencer_inst (
    .mclk_in(clk), .rst_in(rst), .mode_sel_hi_in(md_hi), .mode_sel_lo_in(md_lo),
    .row_strobe_n_in(ras_i), .col_strobe_n_in(cas_i), .write_enable_n_in(we_i),
    .row_col_sel_in(rcs), .refresh_period_clock_in(refresh_period_clock), .refresh_strobe_gen_clock_in(gck),
    .chip_sel_n_in(cs_n), .row_hold_select_in(row_hold_select), .address_latch_strobe_in(address_latch_strobe),
    .row_addr_in(row_a), .col_addr_in(col_a), .bank_sel_lo_in(b_lo), .bank_sel_hi_in(b_hi),
    .refresh_request_io_in(req_wire), .refresh_request_io_out(req_o),
    .refresh_request_io_oe_n_out(req_oe_n), .dram_out(dram));
  dars_partner_model dars_partner_model_inst (
    .mclk_in(clk), .dram_in(dram), .req_data_in(req_o), .req_oe_n_in(req_oe_n),
    .ext_pull_n_in(pull_n), .req_wire_out(req_wire), .row_seen_out(row_seen),
    .col_seen_out(col_seen));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic set_mode(input dars_mode_t m);
    {md_hi, md_lo} = m;
  endtask : set_mode
  // one full generator clock period ending two cycles after its fall
  task automatic gen_fall();
    gck = 1'b1;
    step(2);
    gck = 1'b0;
    step(2);
  endtask : gen_fall
  // one period clock period with no refresh inside it
  task automatic idle_period();
    refresh_period_clock = 1'b1;
    step(2);
    refresh_period_clock = 1'b0;
    step(3);
  endtask : idle_period
  task automatic summarize();
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // ****************************************************************
  // tests
  // ****************************************************************
  // watchdog: the sequence needs about 1120 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    step(3);
    chk(dram.ras_n, 4'hf, "reset row strobes");
    chk({dram.cas_n, dram.we_n, req_oe_n}, 3'h7, "reset strobes");
    chk(dram.addr, 10'h000, "reset address");
    rst = 1'b0;
    // external access, bank 2, auto column strobe, page toggle
    set_mode(MD_EXT_ACC);
    row_a = 10'h2a5;
    col_a = 10'h15a;
    b_hi = 1'b1;
    cas_i = 1'b0;
    we_i = 1'b0;
    step(2);
    ras_i = 1'b0;
    step(2); // select kept high past row hold
    chk(dram.ras_n, 4'hb, "ext bank strobe");
    chk(dram.addr, row_a, "ext row address");
    chk(dram.cas_n, 1'b1, "column blocked");
    chk(dram.we_n, 1'b0, "write follows");
    chk(row_seen, row_a, "dram row latched");
    rcs = 1'b0;
    step(1);
    chk(dram.addr, col_a, "ext column address");
    step(1);
    chk(dram.cas_n, 1'b0, "auto column strobe");
    cas_i = 1'b1;
    step(1);
    chk(dram.cas_n, 1'b1, "column follows high");
    chk(col_seen, col_a, "dram column latched");
    cas_i = 1'b0;
    we_i = 1'b1;
    step(1);
    chk(dram.cas_n, 1'b0, "page column strobe");
    chk(dram.we_n, 1'b1, "write released");
    ras_i = 1'b1;
    cas_i = 1'b1;
    rcs = 1'b1;
    step(2);
    chk(dram.ras_n, 4'hf, "ext strobes idle");
    // automatic access, every bank, both hold choices
    set_mode(MD_AUTO_ACC);
    cs_n = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {b_hi, b_lo} = i[1:0];
      row_hold_select = i[0];
      row_a = 10'h300 + 10'(i);
      col_a = 10'h0c0 + 10'(i);
      step(2);
      ras_i = 1'b0;
      // row stays out for hold + 1 cycles, column one cycle, then the strobe
      for (int k = 1; k <= (i[0] ? 5 : 4); k++) begin
        step(1);
        chk(dram.ras_n, 4'(~(4'h1 << i)), "auto bank strobe");
        chk(dram.addr, (k <= (i[0] ? 3 : 2)) ? row_a : col_a, "auto address");
        chk(dram.cas_n, k == (i[0] ? 5 : 4) ? 1'b0 : 1'b1, "auto column");
      end
      ras_i = 1'b1;
      step(1);
      chk({dram.ras_n, dram.cas_n}, 5'h1f, "auto end");
    end
    // deselected outside a refresh window: nothing happens
    cs_n = 1'b1;
    ras_i = 1'b0;
    step(2);
    chk(dram.ras_n, 4'hf, "deselected");
    ras_i = 1'b1;
    // hidden refresh, then a refused second one in the same period
    refresh_period_clock = 1'b1;
    step(2);
    chk(dram.addr, {1'b0, exp_cnt}, "hidden counter");
    ras_i = 1'b0;
    step(1);
    chk(dram.ras_n, 4'h0, "hidden strobes");
    ras_i = 1'b1; // chip select stays high until here
    exp_cnt++;
    step(2);
    ras_i = 1'b0;
    step(2);
    chk(dram.ras_n, 4'hf, "second hidden refused");
    ras_i = 1'b1;
    refresh_period_clock = 1'b0;
    step(3);
    chk(req_oe_n, 1'b1, "refreshed, no request");
    // hidden refresh spanning the period clock fall
    refresh_period_clock = 1'b1;
    step(2);
    chk(dram.addr, {1'b0, exp_cnt}, "count after hidden");
    ras_i = 1'b0;
    step(1);
    refresh_period_clock = 1'b0;
    step(3);
    chk(dram.ras_n, 4'h0, "hidden completes");
    ras_i = 1'b1;
    exp_cnt++;
    step(3);
    chk(req_oe_n, 1'b1, "spanning counts");
    // request, answered by forced refresh while period clock low
    idle_period();
    chk({req_oe_n, req_o, req_wire}, 3'h0, "request raised");
    set_mode(MD_FORCED);
    step(2);
    chk(dram.addr, {1'b0, exp_cnt}, "forced counter");
    gen_fall();
    chk(dram.ras_n, 4'hf, "forced wait");
    gen_fall();
    chk(dram.ras_n, 4'h0, "forced strobes");
    chk(req_oe_n, 1'b1, "forced release");
    gen_fall();
    chk(dram.ras_n, 4'h0, "forced hold");
    gen_fall();
    chk(dram.ras_n, 4'hf, "forced end");
    exp_cnt++;
    // request answered by external refresh mode
    set_mode(MD_AUTO_ACC);
    idle_period();
    chk(req_oe_n, 1'b0, "request again");
    set_mode(MD_EXT_REF);
    step(2);
    chk(req_oe_n, 1'b1, "ext refresh release");
    chk(dram.addr, {1'b0, exp_cnt}, "ext counter");
    ras_i = 1'b0;
    step(1);
    chk(dram.ras_n, 4'h0, "ext refresh strobes");
    // burst to the wrap point
    while (exp_cnt != 9'h000) begin
      ras_i = 1'b0;
      step(1);
      ras_i = 1'b1;
      step(1);
      exp_cnt++;
    end
    step(2);
    chk(dram.addr, 10'h000, "counter wrap");
    ras_i = 1'b0;
    step(1);
    ras_i = 1'b1;
    step(3);
    chk(dram.addr, 10'h001, "count after wrap");
    pull_n = 1'b0;
    step(2);
    pull_n = 1'b1;
    step(2);
    chk(dram.addr, 10'h000, "external clear");
    summarize();
  end
endmodule : dars_sequencer_tb
`default_nettype wire
